// ### shared/host_port_pkg.sv
// Shared constants for the indirect host register port.
package host_port_pkg;
    localparam int          DATA_W          = 16;
    localparam int          SEL_W           = 2;
    localparam int          STRAP_W         = 9;
    localparam int          HOST_TYPE_W     = 5;
    localparam int          ADDR_W          = 15;

    // Port select codes on the two port select lines.
    localparam logic [1:0]  SEL_INDEX       = 2'h0;
    localparam logic [1:0]  SEL_STATUS      = 2'h1;
    localparam logic [1:0]  SEL_DATA        = 2'h2;
    localparam logic [1:0]  SEL_RESERVED    = 2'h3;

    // Field layout of the target index register.
    localparam int          IDX_DIR_BIT     = 0;
    localparam int          IDX_ADDR_LSB    = 1;
    localparam int          IDX_ADDR_MSB    = 15;
    localparam logic        DIR_READ        = 1'h0;
    localparam logic        DIR_WRITE       = 1'h1;

    // Field layout of the port status register.
    localparam int          STAT_MEM_BIT    = 0;

    // Host bus type field of the configuration straps.
    localparam int          STRAP_TYPE_LSB  = 0;
    localparam int          STRAP_TYPE_MSB  = 4;

    // Reset values.
    localparam logic [15:0] INDEX_RESET     = 16'h0000;
    localparam logic [15:0] STATUS_RESET    = 16'h0000;
    localparam logic [15:0] DATA_RESET      = 16'h0000;
    localparam logic [15:0] RESERVED_READ   = 16'h0000;

    // Read sequencing of the data port.
    typedef enum logic [0:0] {
        PORT_IDLE,
        PORT_READ_WAIT
    } port_state_type;
endpackage

// ### verilog/strap_capture.sv
// Captures the configuration straps once, as chip reset is released.
`timescale 1ns/1ps
module strap_capture #(
    parameter int WIDTH = 9
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] straps_in,
    output logic      [WIDTH-1:0] straps_r,
    output logic                  valid_r
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync2_r;
    logic [WIDTH-1:0] settled_r;
    logic             reset_d_r;

    // Straps are pins, so they pass three stages and a level counts only once the
    // second and third stage agree, keeping a bouncing strap out of the capture.
    always_ff @(posedge clock) begin
        meta_r  <= straps_in;
        sync_r  <= meta_r;
        sync2_r <= sync_r;
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < WIDTH; i++) begin
            if (sync_r[i] == sync2_r[i]) begin
                settled_r[i] <= sync2_r[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        reset_d_r <= reset;
    end

    // The value is taken on the first edge after release and then frozen, so later
    // strap changes have no effect until the next reset.
    always_ff @(posedge clock) begin
        if (reset) begin
            valid_r <= 1'b0;
        end else if (reset_d_r) begin
            straps_r <= settled_r;
            valid_r  <= 1'b1;
        end
    end
endmodule // strap_capture

// ### verilog/indirect_host_register_port.sv
// Parallel indirect host port: index, status and data port registers.
//
// Overview of operation
// - Decode select lines: index, status, data, reserved.
// - Index bits 15..1 address the target location.
// - Status port read-only, resets zero, bit0 only.
// - Status bit 0 shows memory controller busy.
// - Data port carries all 16 data bits.
// - Port works only in indirect interface modes.
// - Straps latched at reset release, then ignored.
`timescale 1ns/1ps
module indirect_host_register_port
    import host_port_pkg::*;
#(
    parameter logic [4:0] INDIRECT_TYPE_A = 5'h0A,
    parameter logic [4:0] INDIRECT_TYPE_B = 5'h0B
) (
    input  wire logic                                clock,
    input  wire logic                                reset,
    input  wire logic [host_port_pkg::STRAP_W-1:0]   config_straps,
    input  wire logic                                chip_select_n,
    input  wire logic                                read_strobe_n,
    input  wire logic                                write_strobe_n,
    input  wire logic [host_port_pkg::SEL_W-1:0]     port_select_lines,
    input  wire logic [host_port_pkg::DATA_W-1:0]    host_data_in,
    output logic      [host_port_pkg::DATA_W-1:0]    host_data_out,
    output logic                                     host_data_oe,
    output logic                                     host_wait,
    output logic                                     indirect_mode,
    input  wire logic                                mem_busy,
    output logic      [host_port_pkg::ADDR_W-1:0]    target_addr,
    output logic                                     target_read,
    output logic                                     target_write,
    output logic      [host_port_pkg::DATA_W-1:0]    target_wdata,
    input  wire logic [host_port_pkg::DATA_W-1:0]    target_rdata,
    input  wire logic                                target_rvalid
);
    import host_port_pkg::*;

    localparam int PIN_W = 3 + SEL_W + DATA_W;

    logic [STRAP_W-1:0] straps_r;
    logic               straps_valid_r;
    logic [PIN_W-1:0]   pin_meta_r;
    logic [PIN_W-1:0]   pin_s2_r;
    logic [PIN_W-1:0]   pin_s3_r;
    logic [PIN_W-1:0]   pin_r;
    logic               cs_n_f;
    logic               rd_n_f;
    logic               wr_n_f;
    logic [SEL_W-1:0]   sel_f;
    logic [DATA_W-1:0]  din_f;
    logic               rd_act;
    logic               wr_act;
    logic               rd_act_d_r;
    logic               wr_act_d_r;
    logic [SEL_W-1:0]   wr_sel_r;
    logic [DATA_W-1:0]  wr_data_r;
    logic               rd_start;
    logic               wr_done;
    logic [HOST_TYPE_W-1:0] host_type;
    logic               mode_ok;
    logic [DATA_W-1:0]  index_r;
    logic [DATA_W-1:0]  status_r;
    logic [DATA_W-1:0]  data_r;
    port_state_type     state_r;
    logic [DATA_W-1:0]  read_mux;

    strap_capture #(
        .WIDTH (STRAP_W)
    ) u_straps (
        .clock     (clock),
        .reset     (reset),
        .straps_in (config_straps),
        .straps_r  (straps_r),
        .valid_r   (straps_valid_r)
    );

    assign host_type = straps_r[STRAP_TYPE_MSB:STRAP_TYPE_LSB];
    assign mode_ok   = straps_valid_r &&
                       (host_type == INDIRECT_TYPE_A || host_type == INDIRECT_TYPE_B);

    always_ff @(posedge clock) begin
        if (reset) begin
            indirect_mode <= 1'b0;
        end else begin
            indirect_mode <= mode_ok;
        end
    end

    // Three stages on every host pin; a level is accepted only once the second and
    // third stage agree, which filters a one-cycle glitch on the strobes.
    always_ff @(posedge clock) begin
        pin_meta_r <= {chip_select_n, read_strobe_n, write_strobe_n,
                       port_select_lines, host_data_in};
        pin_s2_r   <= pin_meta_r;
        pin_s3_r   <= pin_s2_r;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pin_r <= {3'h7, {(SEL_W + DATA_W){1'b0}}};
        end else begin
            for (int i = 0; i < PIN_W; i++) begin
                if (pin_s2_r[i] == pin_s3_r[i]) begin
                    pin_r[i] <= pin_s3_r[i];
                end
            end
        end
    end

    assign cs_n_f = pin_r[PIN_W-1];
    assign rd_n_f = pin_r[PIN_W-2];
    assign wr_n_f = pin_r[PIN_W-3];
    assign sel_f  = pin_r[DATA_W +: SEL_W];
    assign din_f  = pin_r[DATA_W-1:0];

    assign rd_act = indirect_mode && !cs_n_f && !rd_n_f;
    assign wr_act = indirect_mode && !cs_n_f && !wr_n_f;

    always_ff @(posedge clock) begin
        if (reset) begin
            rd_act_d_r <= 1'b0;
            wr_act_d_r <= 1'b0;
            wr_sel_r   <= SEL_RESERVED;
            wr_data_r  <= DATA_RESET;
        end else begin
            rd_act_d_r <= rd_act;
            wr_act_d_r <= wr_act;
            // Select and data are held while the strobe is low and used when it
            // rises, since the host may already change them at that edge.
            if (wr_act) begin
                wr_sel_r  <= sel_f;
                wr_data_r <= din_f;
            end
        end
    end

    assign rd_start = rd_act && !rd_act_d_r;
    assign wr_done  = wr_act_d_r && !wr_act;

    always_ff @(posedge clock) begin
        if (reset) begin
            index_r <= INDEX_RESET;
        end else if (wr_done && wr_sel_r == SEL_INDEX) begin
            index_r <= wr_data_r;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            status_r <= STATUS_RESET;
        end else begin
            status_r               <= STATUS_RESET;
            status_r[STAT_MEM_BIT] <= mem_busy;
        end
    end

    // Writes toward the target go out as a one-cycle pulse when the strobe ends.
    always_ff @(posedge clock) begin
        if (reset) begin
            target_write <= 1'b0;
            target_wdata <= DATA_RESET;
        end else begin
            target_write <= 1'b0;
            if (wr_done && wr_sel_r == SEL_DATA && index_r[IDX_DIR_BIT] == DIR_WRITE) begin
                target_write <= 1'b1;
                target_wdata <= wr_data_r;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            target_addr <= {ADDR_W{1'b0}};
        end else begin
            target_addr <= index_r[IDX_ADDR_MSB:IDX_ADDR_LSB];
        end
    end

    // A data port read with the read direction selected fetches the target and
    // holds the host in wait until the value is back. A read with the write
    // direction selected returns the last data value without a fetch.
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r     <= PORT_IDLE;
            target_read <= 1'b0;
            host_wait   <= 1'b0;
            data_r      <= DATA_RESET;
        end else begin
            target_read <= 1'b0;
            unique case (state_r)
                PORT_IDLE: begin
                    if (rd_start && sel_f == SEL_DATA && index_r[IDX_DIR_BIT] == DIR_READ) begin
                        target_read <= 1'b1;
                        host_wait   <= 1'b1;
                        state_r     <= PORT_READ_WAIT;
                    end
                end
                PORT_READ_WAIT: begin
                    if (target_rvalid) begin
                        data_r    <= target_rdata;
                        host_wait <= 1'b0;
                        state_r   <= PORT_IDLE;
                    end
                end
            endcase
            if (wr_done && wr_sel_r == SEL_DATA) begin
                data_r <= wr_data_r;
            end
        end
    end

    always_comb begin
        read_mux = RESERVED_READ;
        unique case (sel_f)
            SEL_INDEX:    read_mux = index_r;
            SEL_STATUS:   read_mux = status_r;
            SEL_DATA:     read_mux = data_r;
            SEL_RESERVED: read_mux = RESERVED_READ;
        endcase
    end

    // The bus is driven only in an indirect mode and only during a read strobe,
    // so a host bus of another type never sees this port contend.
    always_ff @(posedge clock) begin
        if (reset) begin
            host_data_oe  <= 1'b0;
            host_data_out <= RESERVED_READ;
        end else begin
            host_data_oe  <= rd_act;
            host_data_out <= read_mux;
        end
    end
endmodule // indirect_host_register_port

// ### tb/host_port_monitor.sv
// Concurrent checks on the host port and target side of the port block.
`timescale 1ns/1ps
module host_port_monitor (
    input wire logic clock,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic host_data_oe,
    input wire logic host_wait,
    input wire logic indirect_mode,
    input wire logic target_read,
    input wire logic target_write,
    input wire logic target_rvalid
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_write_one_cycle: assert property (target_write |=> !target_write)
        else $error("target write pulse longer than one cycle");
    a_read_one_cycle: assert property (target_read |=> !target_read)
        else $error("target read pulse longer than one cycle");
    a_read_sets_wait: assert property (target_read |-> host_wait)
        else $error("fetch issued without wait");
    a_write_needs_mode: assert property (target_write |-> indirect_mode)
        else $error("target write outside indirect mode");
    a_read_needs_mode: assert property (target_read |-> indirect_mode)
        else $error("target read outside indirect mode");
    a_wait_released: assert property (host_wait && target_rvalid |=> !host_wait)
        else $error("wait not dropped after read data");
    a_wait_bounded: assert property (host_wait |-> ##[1:24] !host_wait)
        else $error("wait held too long");
    a_idle_no_drive: assert property (chip_select_n [*6] |=> !host_data_oe)
        else $error("bus driven while deselected");

    c_write: cover property (target_write);
    c_read: cover property (target_read ##[1:20] target_rvalid);
    c_mode: cover property ($rose(indirect_mode));
endmodule // host_port_monitor

// ### tb/target_memory_model.sv
// Memory behind the target side, answering fetches after a set latency.
`timescale 1ns/1ps
module target_memory_model (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [14:0] target_addr,
    input  wire logic        target_read,
    input  wire logic        target_write,
    input  wire logic [15:0] target_wdata,
    input  wire logic [3:0]  latency,
    output logic      [15:0] target_rdata,
    output logic             target_rvalid
);
    logic [15:0] mem [32768];
    logic [14:0] addr_r;
    logic [3:0]  count_r;
    logic        pend_r;

    // Read data is scrambled outside the valid pulse so nothing relies on it lingering.
    always @(posedge clock) begin
        target_rvalid <= 1'b0;
        target_rdata  <= ~target_rdata;
        if (reset) begin
            pend_r       <= 1'b0;
            target_rdata <= 16'h0000;
        end else if (target_read) begin
            pend_r  <= 1'b1;
            count_r <= latency;
            addr_r  <= target_addr;
        end else if (pend_r && count_r == 4'h0) begin
            pend_r        <= 1'b0;
            target_rvalid <= 1'b1;
            target_rdata  <= mem[addr_r];
        end else if (pend_r) begin
            count_r <= count_r - 4'h1;
        end
        if (target_write) begin
            mem[target_addr] <= target_wdata;
        end
    end
endmodule // target_memory_model

// ### tb/indirect_host_register_port_tb_top.sv
// Testbench driving host bus cycles into the indirect host port.
`timescale 1ns/1ps
module indirect_host_register_port_tb_top;
    import host_port_pkg::*;
    logic clock = 1'b0, reset = 1'b1, mem_busy = 1'b0, target_rvalid;
    logic chip_select_n = 1'b1, read_strobe_n = 1'b1, write_strobe_n = 1'b1;
    logic [8:0]  config_straps = 9'h00A;
    logic [1:0]  port_select_lines = 2'h0;
    logic [15:0] host_data_in = 16'h0000, host_data_out, target_wdata, target_rdata, d;
    logic [14:0] target_addr, a;
    logic        host_data_oe, host_wait, indirect_mode, target_read, target_write;
    logic [3:0]  latency = 4'h0;
    int          fails = 0, checks = 0;

    always #4 clock = ~clock;

    indirect_host_register_port dut (.clock(clock), .reset(reset),
        .config_straps(config_straps), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .port_select_lines(port_select_lines), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe), .host_wait(host_wait),
        .indirect_mode(indirect_mode), .mem_busy(mem_busy), .target_addr(target_addr),
        .target_read(target_read), .target_write(target_write), .target_wdata(target_wdata),
        .target_rdata(target_rdata), .target_rvalid(target_rvalid));
    target_memory_model partner (.clock(clock), .reset(reset), .target_addr(target_addr),
        .target_read(target_read), .target_write(target_write), .target_wdata(target_wdata),
        .latency(latency), .target_rdata(target_rdata), .target_rvalid(target_rvalid));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Pins are held well past the input filter so each level is seen stable.
    task automatic host_write(input logic [1:0] sel, input logic [15:0] v);
        @(posedge clock);
        chip_select_n <= 1'b0;
        port_select_lines <= sel;
        host_data_in <= v;
        write_strobe_n <= 1'b0;
        idle(6);
        write_strobe_n <= 1'b1;
        idle(2);
        chip_select_n <= 1'b1;
        idle(8);
    endtask
    task automatic host_read(input logic [1:0] sel, output logic [15:0] v);
        @(posedge clock);
        chip_select_n <= 1'b0;
        port_select_lines <= sel;
        read_strobe_n <= 1'b0;
        idle(7);
        #1;
        for (int i = 0; i < 60 && host_wait !== 1'b0; i++) begin
            @(posedge clock);
            #1;
        end
        check("wait released", {15'h0, host_wait}, 16'h0000);
        idle(3);
        #1 v = host_data_out;
        check("bus drive", {15'h0, host_data_oe}, 16'h0001);
        @(posedge clock);
        read_strobe_n <= 1'b1;
        idle(2);
        chip_select_n <= 1'b1;
        idle(8);
    endtask

    initial begin
        idle(8);
        reset <= 1'b0;
        idle(4);
        config_straps <= 9'h000;
        idle(20);
        check("indirect_mode", {15'h0, indirect_mode}, 16'h0001);
        mem_busy <= 1'b1;
        host_read(SEL_STATUS, d);
        check("status busy", d, 16'h0001);
        mem_busy <= 1'b0;
        host_read(SEL_STATUS, d);
        check("status idle", d, 16'h0000);
        host_write(SEL_INDEX, 16'hB6C9);
        host_write(SEL_STATUS, 16'hFFFF);
        host_write(SEL_RESERVED, 16'h5A5A);
        host_read(SEL_STATUS, d);
        check("status after write", d, 16'h0000);
        host_read(SEL_RESERVED, d);
        check("reserved read", d, 16'h0000);
        host_read(SEL_INDEX, d);
        check("index readback", d, 16'hB6C9);
        check("target_addr", {1'b0, target_addr}, 16'h5B64);
        for (int k = 0; k < 2; k++) begin
            a = k ? 15'h7FFF : 15'h0001;
            latency <= k ? 4'h9 : 4'h0;
            host_read(SEL_STATUS, d);
            check("poll idle", d, 16'h0000);
            host_write(SEL_INDEX, {a, DIR_WRITE});
            host_write(SEL_DATA, k ? 16'hFFFF : 16'h8001);
            check("memory write", partner.mem[a], k ? 16'hFFFF : 16'h8001);
            host_write(SEL_INDEX, {a, DIR_READ});
            host_write(SEL_DATA, 16'h1234);
            check("no write on read dir", partner.mem[a], k ? 16'hFFFF : 16'h8001);
            host_read(SEL_DATA, d);
            check("memory read", d, k ? 16'hFFFF : 16'h8001);
        end
        reset <= 1'b1;
        idle(8);
        reset <= 1'b0;
        idle(20);
        check("mode off", {15'h0, indirect_mode}, 16'h0000);
        host_write(SEL_INDEX, {15'h0001, DIR_WRITE});
        host_write(SEL_DATA, 16'h4242);
        check("write ignored", partner.mem[1], 16'h8001);
        config_straps <= 9'h00B;
        reset <= 1'b1;
        idle(8);
        reset <= 1'b0;
        idle(20);
        check("mode type b", {15'h0, indirect_mode}, 16'h0001);
        host_read(SEL_INDEX, d);
        check("index after reset", d, 16'h0000);
        tally_and_finish();
    end

    initial begin
        idle(20000);
        fails++;
        tally_and_finish();
    end
endmodule // indirect_host_register_port_tb_top

bind indirect_host_register_port host_port_monitor mon (.clock(clock), .reset(reset),
    .chip_select_n(chip_select_n), .host_data_oe(host_data_oe), .host_wait(host_wait),
    .indirect_mode(indirect_mode), .target_read(target_read),
    .target_write(target_write), .target_rvalid(target_rvalid));
